// ==== core/irq_vector_lowpower_defines.svh ====
// constants for the interrupt vectoring and low-power mode controller
// assumes inclusion by bare name from core/
`ifndef IRQ_VECTOR_LOWPOWER_DEFINES_SVH
`define IRQ_VECTOR_LOWPOWER_DEFINES_SVH
`define VEC_TABLE_BASE    16'hffc0
`define VEC_RESET         16'hfffe
`define VEC_NMI           16'hfffc
`define VEC_T2_CH0        16'hfffa
`define VEC_T2_OTHER      16'hfff8
`define VEC_WDT_INTERVAL  16'hfff4
`define VEC_T1_CH0        16'hfff2
`define VEC_T1_OTHER      16'hfff0
`define VEC_SERIAL_RX     16'hffee
`define VEC_SERIAL_TX     16'hffec
`define VEC_CONVERTER     16'hffea
`define VEC_PORT2         16'hffe6
`define VEC_PORT1         16'hffe4
`define VEC_BOOT_KEY      16'hffde
`define RESET_VEC_BLANK   16'hffff
`define BOOT_KEY_DISABLE  16'haa55
`define BOOT_KEY_NO_ERASE 16'h0000
`define PERIPH_AREA_TOP   16'h01ff
`define PRIO_RESET        5'd31
`define PRIO_NMI          5'd30
`define PRIO_NONE         5'd0
`define REG_MODE          4'h0
`define REG_CTRL          4'h1
`define REG_STATUS        4'h2
`define REG_VECTOR        4'h3
`define REG_RESET_WORD    4'h4
`define REG_BOOT_KEY      4'h5
`define REG_USED_TOP      4'h6
`define REG_USED_LOW      4'h7
`define RANGE_RESET_LOW   16'h1000
`define RANGE_RESET_TOP   16'hffff
`endif

// ==== core/irq_vector_lowpower_pkg.sv ====
// types for the interrupt vectoring and low-power mode controller
// assumes nothing beyond a SystemVerilog compiler
package irq_vector_lowpower_pkg;
  typedef enum logic [2:0] {
    active_run_mode,
    sleep_mode_0,
    sleep_mode_1,
    sleep_mode_2,
    sleep_mode_3,
    sleep_mode_4
  } power_mode_t;
  typedef enum logic [1:0] {
    st_idle,
    st_vector,
    st_handler
  } irq_state_t;
endpackage

// ==== core/irq_vector_lowpower_ctrl.sv ====
// interrupt vectoring, reset sourcing and low-power clock gating
// assumes same-clock peripheral flags, a core that acks vectors and
// reports interrupt return, and one-cycle register strobes
//
// Functional notes
// - vectors and start address live in the top 64 bytes, 16-bit each
// - blank reset vector word sends the device into sleep mode 4 at power-up
// - power-up, pin, watchdog, key violation, bad fetch use reset vector, priority 31
// - instruction fetch from peripheral area or unused ranges causes a reset
// - pin nmi, oscillator fault, flash access violation share priority 30
// - non-maskable sources obey own enable, ignore global enable
// - timer and watchdog interval vectors at fixed addresses and priorities
// - serial receive requests share 23, transmit requests share 22
// - i2c routes status to receive, rx and tx to transmit; spi routes own
// - port 2 flags on priority 19, port 1 flags on priority 18
// - timer, converter, port flags stay in their peripherals
// - slots below the boot key word are unused and never vectored
// - boot key 0xaa55 disables bootloader; zero blocks erase on bad password
// - five sleep modes, any interrupt wakes, return restores prior mode
// - active mode runs main, sub-main and auxiliary clocks
// - sleep mode 0 halts cpu and main clock, keeps others
// - sleep mode 1 as mode 0, bias off if oscillator unused when active
// - sleep mode 2 stops main and sub-main, keeps bias and auxiliary
// - sleep mode 3 keeps only auxiliary clock, bias off
// - sleep mode 4 stops all clocks, bias and crystal
`timescale 1ns/100ps
`include "irq_vector_lowpower_defines.svh"
module irq_vector_lowpower_ctrl
  import irq_vector_lowpower_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        POWER_UP_FLAG,
  input  wire logic        EXT_RESET_FLAG,
  input  wire logic        WATCHDOG_FLAG,
  input  wire logic        FLASH_KEY_VIOLATION_FLAG,
  input  wire logic        PIN_NMI_FLAG,
  input  wire logic        OSC_FAULT_FLAG,
  input  wire logic        FLASH_ACCESS_VIOLATION_FLAG,
  input  wire logic        PIN_NMI_EN,
  input  wire logic        OSC_FAULT_EN,
  input  wire logic        FLASH_ACCESS_VIOLATION_EN,
  input  wire logic        T2_CH0_REQ,
  input  wire logic        T2_OTHER_REQ,
  input  wire logic        WDT_INTERVAL_REQ,
  input  wire logic        T1_CH0_REQ,
  input  wire logic        T1_OTHER_REQ,
  input  wire logic        SERIAL_A_RX_FLAG,
  input  wire logic        SERIAL_A_TX_FLAG,
  input  wire logic        SERIAL_B_RX_FLAG,
  input  wire logic        SERIAL_B_TX_FLAG,
  input  wire logic        ARBITRATION_LOST_FLAG,
  input  wire logic        NO_ACK_FLAG,
  input  wire logic        START_COND_FLAG,
  input  wire logic        STOP_COND_FLAG,
  input  wire logic        SERIAL_B_I2C_MODE,
  input  wire logic        CONVERTER_DONE_FLAG,
  input  wire logic [7:0]  PORT2_PIN_FLAGS,
  input  wire logic [7:0]  PORT1_PIN_FLAGS,
  input  wire logic        GLOBAL_IRQ_EN,
  input  wire logic        FETCH_VALID,
  input  wire logic [15:0] FETCH_ADDR,
  input  wire logic        VECTOR_ACK,
  input  wire logic        IRQ_RETURN,
  input  wire logic        DCO_USED_ACTIVE,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  output logic             IRQ_REQ,
  output logic      [15:0] VECTOR_ADDR,
  output logic      [4:0]  IRQ_PRIORITY,
  output logic             CPU_RESET_REQ,
  output logic             CPU_HALT,
  output logic             MAIN_CLK_EN,
  output logic             SUBMAIN_CLK_EN,
  output logic             AUX_CLK_EN,
  output logic             DCO_BIAS_EN,
  output logic             XTAL_EN,
  output logic             BOOT_LOADER_DISABLE,
  output logic             ERASE_ON_BAD_PW_BLOCK
);

  power_mode_t mode;
  power_mode_t saved_mode;
  power_mode_t next_mode;
  irq_state_t  state;
  logic [15:0] reset_word;
  logic [15:0] boot_loader_key_word;
  logic [15:0] used_top;
  logic [15:0] used_low;
  logic        reset_word_loaded;
  logic        bad_fetch;
  logic        reset_src;
  logic        nmi_req;
  logic        rx_req;
  logic        tx_req;
  logic        maskable_on;
  logic [4:0]  win_prio;
  logic [15:0] win_vec;

  // address of a vector slot from its priority
  function automatic logic [15:0] slot_addr(input logic [4:0] prio);
    slot_addr = `VEC_TABLE_BASE + {10'h000, prio, 1'b0};
  endfunction

  // fetch inside the peripheral area or outside the implemented memory
  function automatic logic fetch_illegal(input logic [15:0] a,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
    fetch_illegal = (a <= `PERIPH_AREA_TOP) || (a < lo) || (a > hi);
  endfunction

  assign bad_fetch = FETCH_VALID && fetch_illegal(FETCH_ADDR, used_low, used_top);
  assign reset_src = POWER_UP_FLAG || EXT_RESET_FLAG || WATCHDOG_FLAG
                   || FLASH_KEY_VIOLATION_FLAG || bad_fetch;
  assign nmi_req   = (PIN_NMI_FLAG && PIN_NMI_EN) || (OSC_FAULT_FLAG && OSC_FAULT_EN)
                   || (FLASH_ACCESS_VIOLATION_FLAG && FLASH_ACCESS_VIOLATION_EN);
  assign rx_req    = SERIAL_B_I2C_MODE
                   ? (SERIAL_A_RX_FLAG || ARBITRATION_LOST_FLAG || NO_ACK_FLAG
                      || START_COND_FLAG || STOP_COND_FLAG)
                   : (SERIAL_A_RX_FLAG || SERIAL_B_RX_FLAG);
  assign tx_req    = SERIAL_B_I2C_MODE
                   ? (SERIAL_A_TX_FLAG || SERIAL_B_RX_FLAG || SERIAL_B_TX_FLAG)
                   : (SERIAL_A_TX_FLAG || SERIAL_B_TX_FLAG);
  assign maskable_on = GLOBAL_IRQ_EN;

  // fixed priority pick; flags are read live from the peripherals
  always_comb begin
    win_prio = `PRIO_NONE;
    win_vec  = `VEC_RESET;
    if (nmi_req) begin
      win_prio = `PRIO_NMI;
      win_vec  = `VEC_NMI;
    end else if (maskable_on) begin
      if (T2_CH0_REQ) begin
        win_prio = 5'd29;
      end else if (T2_OTHER_REQ) begin
        win_prio = 5'd28;
      end else if (WDT_INTERVAL_REQ) begin
        win_prio = 5'd26;
      end else if (T1_CH0_REQ) begin
        win_prio = 5'd25;
      end else if (T1_OTHER_REQ) begin
        win_prio = 5'd24;
      end else if (rx_req) begin
        win_prio = 5'd23;
      end else if (tx_req) begin
        win_prio = 5'd22;
      end else if (CONVERTER_DONE_FLAG) begin
        win_prio = 5'd21;
      end else if (|PORT2_PIN_FLAGS) begin
        win_prio = 5'd19;
      end else if (|PORT1_PIN_FLAGS) begin
        win_prio = 5'd18;
      end
      // slots 15 and below never win
      win_vec = slot_addr(win_prio);
    end
  end

  // vector handshake with the core
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state        <= st_idle;
      IRQ_REQ      <= 1'b0;
      VECTOR_ADDR  <= `VEC_RESET;
      IRQ_PRIORITY <= `PRIO_RESET;
    end else begin
      unique case (state)
        st_idle: begin
          if (win_prio != `PRIO_NONE) begin
            state        <= st_vector;
            IRQ_REQ      <= 1'b1;
            VECTOR_ADDR  <= win_vec;
            IRQ_PRIORITY <= win_prio;
          end
        end
        st_vector: begin
          if (VECTOR_ACK) begin
            state   <= st_handler;
            IRQ_REQ <= 1'b0;
          end else if (win_prio > IRQ_PRIORITY) begin
            VECTOR_ADDR  <= win_vec;
            IRQ_PRIORITY <= win_prio;
          end
        end
        st_handler: begin
          if (IRQ_RETURN) begin
            state <= st_idle;
          end
        end
      endcase
    end
  end

  // reset request to the core
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      CPU_RESET_REQ <= 1'b1;
    end else begin
      CPU_RESET_REQ <= reset_src;
    end
  end

  // operating mode: software entry, wake on interrupt, restore on return
  always_comb begin
    next_mode = mode;
    if (reset_word_loaded && reset_word == `RESET_VEC_BLANK) begin
      next_mode = sleep_mode_4;
    end else if (REG_WR && REG_ADDR == `REG_MODE) begin
      unique case (REG_WDATA[2:0])
        3'h1:    next_mode = sleep_mode_0;
        3'h2:    next_mode = sleep_mode_1;
        3'h3:    next_mode = sleep_mode_2;
        3'h4:    next_mode = sleep_mode_3;
        3'h5:    next_mode = sleep_mode_4;
        default: next_mode = active_run_mode;
      endcase
    end else if (state == st_idle && win_prio != `PRIO_NONE) begin
      next_mode = active_run_mode;
    end else if (state == st_handler && IRQ_RETURN) begin
      next_mode = saved_mode;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      mode       <= active_run_mode;
      saved_mode <= active_run_mode;
    end else begin
      mode <= next_mode;
      if (state == st_idle && win_prio != `PRIO_NONE) begin
        saved_mode <= mode;
      end
    end
  end

  // clock and oscillator gating by mode
  always_comb begin
    CPU_HALT       = 1'b1;
    MAIN_CLK_EN    = 1'b0;
    SUBMAIN_CLK_EN = 1'b0;
    AUX_CLK_EN     = 1'b1;
    DCO_BIAS_EN    = 1'b0;
    XTAL_EN        = 1'b1;
    unique case (mode)
      active_run_mode: begin
        CPU_HALT       = 1'b0;
        MAIN_CLK_EN    = 1'b1;
        SUBMAIN_CLK_EN = 1'b1;
        DCO_BIAS_EN    = 1'b1;
      end
      sleep_mode_0: begin
        SUBMAIN_CLK_EN = 1'b1;
        DCO_BIAS_EN    = 1'b1;
      end
      sleep_mode_1: begin
        SUBMAIN_CLK_EN = 1'b1;
        DCO_BIAS_EN    = DCO_USED_ACTIVE;
      end
      sleep_mode_2: begin
        DCO_BIAS_EN = 1'b1;
      end
      sleep_mode_3: begin
        DCO_BIAS_EN = 1'b0;
      end
      sleep_mode_4: begin
        AUX_CLK_EN = 1'b0;
        XTAL_EN    = 1'b0;
      end
    endcase
  end

  // boot key word decode
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      BOOT_LOADER_DISABLE   <= 1'b0;
      ERASE_ON_BAD_PW_BLOCK <= 1'b0;
    end else begin
      BOOT_LOADER_DISABLE   <= boot_loader_key_word == `BOOT_KEY_DISABLE;
      ERASE_ON_BAD_PW_BLOCK <= boot_loader_key_word == `BOOT_KEY_NO_ERASE;
    end
  end

  // memory image words and implemented range, loaded by software
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      reset_word           <= 16'h0000;
      reset_word_loaded    <= 1'b0;
      boot_loader_key_word <= 16'hffff;
      used_top             <= `RANGE_RESET_TOP;
      used_low             <= `RANGE_RESET_LOW;
    end else begin
      reset_word_loaded <= 1'b0;
      if (REG_WR && REG_ADDR == `REG_RESET_WORD) begin
        reset_word        <= REG_WDATA;
        reset_word_loaded <= 1'b1;
      end
      if (REG_WR && REG_ADDR == `REG_BOOT_KEY) begin
        boot_loader_key_word <= REG_WDATA;
      end
      if (REG_WR && REG_ADDR == `REG_USED_TOP) begin
        used_top <= REG_WDATA;
      end
      if (REG_WR && REG_ADDR == `REG_USED_LOW) begin
        used_low <= REG_WDATA;
      end
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        `REG_MODE:       REG_RDATA <= {13'h0000, mode};
        `REG_CTRL:       REG_RDATA <= {13'h0000, saved_mode};
        `REG_STATUS:     REG_RDATA <= {8'h00, IRQ_PRIORITY, 1'b0, state};
        `REG_VECTOR:     REG_RDATA <= VECTOR_ADDR;
        `REG_RESET_WORD: REG_RDATA <= reset_word;
        `REG_BOOT_KEY:   REG_RDATA <= boot_loader_key_word;
        `REG_USED_TOP:   REG_RDATA <= used_top;
        `REG_USED_LOW:   REG_RDATA <= used_low;
        default:         REG_RDATA <= 16'h0000;
      endcase
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

endmodule

// ==== bench/irq_vector_lowpower_ctrl_assertions.sv ====
// port checks for the interrupt vectoring and low-power controller
// assumes a bind onto irq_vector_lowpower_ctrl with one clock
`timescale 1ns/100ps
module irq_vector_lowpower_ctrl_assertions (
  input logic        CLK,
  input logic        RST_B,
  input logic        POWER_UP_FLAG,
  input logic        EXT_RESET_FLAG,
  input logic        WATCHDOG_FLAG,
  input logic        FLASH_KEY_VIOLATION_FLAG,
  input logic        FETCH_VALID,
  input logic [15:0] FETCH_ADDR,
  input logic        DCO_USED_ACTIVE,
  input logic [3:0]  REG_ADDR,
  input logic [15:0] REG_WDATA,
  input logic        REG_WR,
  input logic        VECTOR_ACK,
  input logic        IRQ_REQ,
  input logic [15:0] VECTOR_ADDR,
  input logic [4:0]  IRQ_PRIORITY,
  input logic        CPU_RESET_REQ,
  input logic        CPU_HALT,
  input logic        MAIN_CLK_EN,
  input logic        SUBMAIN_CLK_EN,
  input logic        AUX_CLK_EN,
  input logic        DCO_BIAS_EN,
  input logic        XTAL_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  a_reset_sources: assert property (
    (POWER_UP_FLAG || EXT_RESET_FLAG || WATCHDOG_FLAG || FLASH_KEY_VIOLATION_FLAG)
    |=> CPU_RESET_REQ) else $error("reset source gave no cpu reset");
  a_fetch_reset: assert property (FETCH_VALID && FETCH_ADDR <= 16'h01ff |=> CPU_RESET_REQ)
    else $error("fetch from register area gave no reset");
  a_blank_word: assert property (
    REG_WR && REG_ADDR == 4'h4 && REG_WDATA == 16'hffff |-> ##2 CPU_HALT && !XTAL_EN)
    else $error("blank reset word did not enter deepest sleep");
  a_active_clocks: assert property (
    !CPU_HALT |-> MAIN_CLK_EN && SUBMAIN_CLK_EN && AUX_CLK_EN)
    else $error("active mode with a clock stopped");
  a_halt_main_off: assert property (CPU_HALT |-> !MAIN_CLK_EN)
    else $error("main clock running while halted");
  a_bias_kept: assert property (
    CPU_HALT && SUBMAIN_CLK_EN && DCO_USED_ACTIVE |-> DCO_BIAS_EN)
    else $error("bias stopped although oscillator in use");
  a_deep_sleep: assert property (
    CPU_HALT && !AUX_CLK_EN |-> !SUBMAIN_CLK_EN && !DCO_BIAS_EN && !XTAL_EN)
    else $error("deepest sleep left a source running");
  a_slot_address: assert property (IRQ_REQ |-> VECTOR_ADDR == {10'h3ff, IRQ_PRIORITY, 1'b0})
    else $error("vector word does not match priority slot");
  a_used_slots: assert property (
    IRQ_REQ |-> IRQ_PRIORITY >= 5'h12 && IRQ_PRIORITY != 5'h1f)
    else $error("vectored an unused slot");
  a_wake_cpu: assert property ($rose(IRQ_REQ) |-> !CPU_HALT)
    else $error("request raised while still halted");
  a_req_holds: assert property (IRQ_REQ && !VECTOR_ACK |=> IRQ_REQ)
    else $error("pending request dropped before ack");
endmodule

// ==== bench/cpu_core_model.sv ====
// behavioural cpu core: acks a raised vector, then returns from it
// assumes the controller's registered request on the same clock
`timescale 1ns/100ps
module cpu_core_model (
  input  logic       CLK,
  input  logic       RST_B,
  input  logic       IRQ_REQ,
  input  logic [3:0] ack_delay,
  output logic       VECTOR_ACK,
  output logic       IRQ_RETURN
);
  logic       in_handler;
  logic [3:0] cnt;
  // ack after ack_delay cycles of request, return five cycles later
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      in_handler <= 1'b0;
      cnt        <= 4'h0;
      VECTOR_ACK <= 1'b0;
      IRQ_RETURN <= 1'b0;
    end else begin
      VECTOR_ACK <= 1'b0;
      IRQ_RETURN <= 1'b0;
      cnt        <= cnt + 4'h1;
      if (!in_handler && IRQ_REQ !== 1'b1) begin
        cnt <= 4'h0;
      end else if (!in_handler && cnt == ack_delay) begin
        VECTOR_ACK <= 1'b1;
        in_handler <= 1'b1;
        cnt        <= 4'h0;
      end else if (in_handler && cnt == 4'h4) begin
        IRQ_RETURN <= 1'b1;
        in_handler <= 1'b0;
        cnt        <= 4'h0;
      end
    end
  end
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the interrupt vectoring and low-power controller
// assumes the cpu core model and the port checker in bench/
`timescale 1ns/100ps
module testbench;
  typedef struct {logic [4:0] idx; logic i2c; logic gie; logic [15:0] vec;
                  logic [4:0] pri;} row_t;
  typedef struct {logic [15:0] code; logic digital_ctrl_oscillator; logic [15:0] exp;} mode_row_t;
  logic        CLK, RST_B, SERIAL_B_I2C_MODE, GLOBAL_IRQ_EN, FETCH_VALID, DCO_USED_ACTIVE;
  logic        REG_WR, REG_RD, VECTOR_ACK, IRQ_RETURN, IRQ_REQ, CPU_RESET_REQ, CPU_HALT;
  logic        MAIN_CLK_EN, SUBMAIN_CLK_EN, AUX_CLK_EN, DCO_BIAS_EN, XTAL_EN;
  logic        BOOT_LOADER_DISABLE, ERASE_ON_BAD_PW_BLOCK;
  logic [3:0]  REG_ADDR, rst_src, ack_delay;
  logic [15:0] REG_WDATA, REG_RDATA, VECTOR_ADDR, FETCH_ADDR, rd, ek;
  logic [4:0]  IRQ_PRIORITY;
  logic [18:0] src;
  logic [2:0]  nmi_en;
  int          fail_count = 0, n_tests = 0, cycles = 0;
  wire  [15:0] gates = {10'h0, CPU_HALT, MAIN_CLK_EN, SUBMAIN_CLK_EN, AUX_CLK_EN,
                        DCO_BIAS_EN, XTAL_EN};
  row_t rows [21] = '{'{0,0,1,16'hfffa,29}, '{1,0,1,16'hfff8,28}, '{2,0,1,16'hfff4,26},
    '{3,0,1,16'hfff2,25}, '{4,0,1,16'hfff0,24}, '{5,0,1,16'hffee,23}, '{6,0,1,16'hffec,22},
    '{7,0,1,16'hffee,23}, '{7,1,1,16'hffec,22}, '{8,0,1,16'hffec,22}, '{8,1,1,16'hffec,22},
    '{9,1,1,16'hffee,23}, '{10,1,1,16'hffee,23}, '{11,1,1,16'hffee,23},
    '{12,1,1,16'hffee,23}, '{13,0,1,16'hffea,21}, '{14,0,1,16'hffe6,19},
    '{15,0,1,16'hffe4,18}, '{16,0,0,16'hfffc,30}, '{17,0,0,16'hfffc,30},
    '{18,0,0,16'hfffc,30}};
  mode_row_t mrows [6] = '{'{16'h1,0,16'h2f}, '{16'h2,0,16'h2d}, '{16'h2,1,16'h2f},
    '{16'h3,0,16'h27}, '{16'h4,0,16'h25}, '{16'h5,0,16'h20}};
  logic [15:0] fa [6] = '{16'h0000, 16'h01ff, 16'h0200, 16'h0fff, 16'h1000, 16'hffff};
  logic [15:0] keys [3] = '{16'haa55, 16'h0000, 16'h1234};
  logic [3:0]  ra [5] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'hf};
  logic [15:0] re [5] = '{16'h0, 16'hffff, 16'hffff, 16'h1000, 16'h0};

  irq_vector_lowpower_ctrl dut (.CLK, .RST_B, .POWER_UP_FLAG(rst_src[0]),
    .EXT_RESET_FLAG(rst_src[1]), .WATCHDOG_FLAG(rst_src[2]),
    .FLASH_KEY_VIOLATION_FLAG(rst_src[3]), .PIN_NMI_FLAG(src[16]), .OSC_FAULT_FLAG(src[17]),
    .FLASH_ACCESS_VIOLATION_FLAG(src[18]), .PIN_NMI_EN(nmi_en[0]), .OSC_FAULT_EN(nmi_en[1]),
    .FLASH_ACCESS_VIOLATION_EN(nmi_en[2]), .T2_CH0_REQ(src[0]), .T2_OTHER_REQ(src[1]),
    .WDT_INTERVAL_REQ(src[2]), .T1_CH0_REQ(src[3]), .T1_OTHER_REQ(src[4]),
    .SERIAL_A_RX_FLAG(src[5]), .SERIAL_A_TX_FLAG(src[6]), .SERIAL_B_RX_FLAG(src[7]),
    .SERIAL_B_TX_FLAG(src[8]), .ARBITRATION_LOST_FLAG(src[9]), .NO_ACK_FLAG(src[10]),
    .START_COND_FLAG(src[11]), .STOP_COND_FLAG(src[12]), .CONVERTER_DONE_FLAG(src[13]),
    .PORT2_PIN_FLAGS({src[14], 7'h0}), .PORT1_PIN_FLAGS({7'h0, src[15]}),
    .SERIAL_B_I2C_MODE, .GLOBAL_IRQ_EN, .FETCH_VALID, .FETCH_ADDR, .VECTOR_ACK, .IRQ_RETURN,
    .DCO_USED_ACTIVE, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .IRQ_REQ,
    .VECTOR_ADDR, .IRQ_PRIORITY, .CPU_RESET_REQ, .CPU_HALT, .MAIN_CLK_EN, .SUBMAIN_CLK_EN,
    .AUX_CLK_EN, .DCO_BIAS_EN, .XTAL_EN, .BOOT_LOADER_DISABLE, .ERASE_ON_BAD_PW_BLOCK);
  cpu_core_model core (.CLK, .RST_B, .IRQ_REQ, .ack_delay, .VECTOR_ACK, .IRQ_RETURN);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 rd = REG_RDATA;
  endtask
  // wait for the vector, check it, clear sources at ack, end at return
  task automatic service(input logic [15:0] vec, input logic [4:0] pri);
    int n;
    n = 0;
    #1;
    while (IRQ_REQ !== 1'b1 && n < 20) begin
      @(posedge CLK);
      #1 n++;
    end
    check(VECTOR_ADDR, vec);
    check({11'h0, IRQ_PRIORITY}, {11'h0, pri});
    check({15'h0, CPU_HALT}, 16'h0);
    n = 0;
    while (IRQ_RETURN !== 1'b1 && n < 40) begin
      @(posedge CLK);
      if (VECTOR_ACK === 1'b1)
        src <= '0;
      n++;
    end
    check({15'h0, n < 40}, 16'h1);
  endtask

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    {RST_B, SERIAL_B_I2C_MODE, GLOBAL_IRQ_EN, FETCH_VALID, DCO_USED_ACTIVE} = 5'h0;
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA, rst_src, src} = '0;
    ack_delay  = 4'h1;
    nmi_en     = 3'h7;
    FETCH_ADDR = 16'hc000;
    repeat (5) @(posedge CLK);
    #1 check(gates, 16'h1f);
    @(posedge CLK);
    RST_B <= 1'b1;
    foreach (ra[i]) begin
      reg_rd(ra[i]);
      check(rd, re[i]);
    end
    foreach (rows[i]) begin
      @(posedge CLK);
      SERIAL_B_I2C_MODE <= rows[i].i2c;
      GLOBAL_IRQ_EN     <= rows[i].gie;
      ack_delay         <= {2'h0, rows[i].idx[1:0]};
      src[rows[i].idx]  <= 1'b1;
      service(rows[i].vec, rows[i].pri);
    end
    // a higher request replaces a waiting one; non-maskable beats maskable
    @(posedge CLK);
    GLOBAL_IRQ_EN <= 1'b1;
    ack_delay     <= 4'h6;
    src[15]       <= 1'b1;
    repeat (2) @(posedge CLK);
    src[0] <= 1'b1;
    @(posedge CLK);
    service(16'hfffa, 5'h1d);
    src[16] <= 1'b1;
    src[2]  <= 1'b1;
    service(16'hfffc, 5'h1e);
    // own enable blocks non-maskable, global enable blocks maskable
    nmi_en        <= 3'h6;
    GLOBAL_IRQ_EN <= 1'b0;
    src[16]       <= 1'b1;
    src[3]        <= 1'b1;
    repeat (6) @(posedge CLK);
    #1 check({15'h0, IRQ_REQ}, 16'h0);
    @(posedge CLK);
    GLOBAL_IRQ_EN <= 1'b1;
    src[16]       <= 1'b0;
    nmi_en        <= 3'h7;
    service(16'hfff2, 5'h19);
    foreach (mrows[i]) begin
      @(posedge CLK);
      DCO_USED_ACTIVE <= mrows[i].digital_ctrl_oscillator;
      reg_wr(4'h0, mrows[i].code);
      #1 check(gates, mrows[i].exp);
      reg_rd(4'h0);
      check(rd, mrows[i].code);
      @(posedge CLK);
      src[3] <= 1'b1;
      service(16'hfff2, 5'h19);
      #1 check(gates, mrows[i].exp);
    end
    reg_wr(4'h0, 16'h0);
    #1 check(gates, 16'h1f);
    reg_wr(4'h4, 16'hffff);
    @(posedge CLK);
    #1 check(gates, 16'h20);
    @(posedge CLK);
    RST_B <= 1'b0;
    repeat (2) @(posedge CLK);
    #1 check(gates, 16'h1f);
    @(posedge CLK);
    RST_B <= 1'b1;
    foreach (keys[i]) begin
      reg_wr(4'h5, keys[i]);
      @(posedge CLK);
      ek = {14'h0, keys[i] == 16'haa55, keys[i] == 16'h0000};
      #1 check({14'h0, BOOT_LOADER_DISABLE, ERASE_ON_BAD_PW_BLOCK}, ek);
    end
    foreach (fa[i]) begin
      @(posedge CLK);
      FETCH_VALID <= 1'b1;
      FETCH_ADDR  <= fa[i];
      @(posedge CLK);
      FETCH_VALID <= 1'b0;
      #1 check({15'h0, CPU_RESET_REQ}, {15'h0, fa[i] < 16'h1000});
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      rst_src <= 4'h1 << i;
      @(posedge CLK);
      rst_src <= 4'h0;
      #1 check({15'h0, CPU_RESET_REQ}, 16'h1);
    end
    end_of_test();
  end
endmodule

bind irq_vector_lowpower_ctrl irq_vector_lowpower_ctrl_assertions chk (.CLK, .RST_B,
  .POWER_UP_FLAG, .EXT_RESET_FLAG, .WATCHDOG_FLAG, .FLASH_KEY_VIOLATION_FLAG, .FETCH_VALID,
  .FETCH_ADDR, .DCO_USED_ACTIVE, .REG_ADDR, .REG_WDATA, .REG_WR, .VECTOR_ACK, .IRQ_REQ,
  .VECTOR_ADDR, .IRQ_PRIORITY, .CPU_RESET_REQ, .CPU_HALT, .MAIN_CLK_EN, .SUBMAIN_CLK_EN,
  .AUX_CLK_EN, .DCO_BIAS_EN, .XTAL_EN);
